// [design/dptr_params.svh]
`ifndef DPTR_PARAMS_SVH
`define DPTR_PARAMS_SVH
// ==================================================================
// Register addresses of the pointer unit.
`define ADDR_SEL_LOW   8'h82
`define ADDR_SEL_HIGH  8'h83
`define ADDR_ALT_LOW   8'hD4
`define ADDR_ALT_HIGH  8'hD5
`define ADDR_AUX_ONE   8'hA2
`define ADDR_PTR_CFG   8'hA1
// ==================================================================
// Field positions.
`define AUX_SEL_BIT    0
`define AUX_ZERO_BIT   2
`define CFG_DEC0_BIT   4
`define CFG_DEC1_BIT   5
`define CFG_UPD0_BIT   6
`define CFG_UPD1_BIT   7
// ==================================================================
// Reset values and opcodes.
`define PTR_RESET      16'h0000
`define CFG_RESET      4'h0
`define AUX_OTHER_RST  4'h0
`define PREFIX_OPCODE  8'hA5
`define BYTE_ZERO      8'h00
`endif

// [design/dptr_pkg.sv]
package dptr_pkg;
  // ================================================================
  // Pointer operations requested by the instruction decoder.
  typedef enum logic [6:0] {
    OP_NONE  = 7'b000_0001,
    OP_LOAD  = 7'b000_0010,
    OP_INC   = 7'b000_0100,
    OP_CODE  = 7'b000_1000,
    OP_XRD   = 7'b001_0000,
    OP_XWR   = 7'b010_0000,
    OP_JMP   = 7'b100_0000
  } ptr_op_t;
endpackage

// [design/dual_data_pointer_unit.sv]
`timescale 1ns/1ps
`include "dptr_params.svh"
// Overview of operation
// - two independent 16-bit address pointers
// - select bit picks default pointer
// - selected pointer at 82H and 83H
// - other pointer at D4H and D5H
// - byte pair mapping swaps with select
// - auxiliary bit 2 reads zero always
// - prefix A5H inverts pointer choice
// - indirect jump ignores the prefix
// - load, increment, reads, writes obey prefix
// - direction bit turns increment into decrement
// - direction bits steer auto updates too
// - enabled auto update after memory access
// - select is auxiliary A2H bit 0
// - configuration upper nibble resets zero
module dual_data_pointer_unit
  import dptr_pkg::*;
#(
  parameter int PTR_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       sfr_addr_i,
  input  wire logic             sfr_wr_i,
  input  wire logic [7:0]       sfr_wdata_i,
  output logic      [7:0]       sfr_rdata_o,
  output logic                  sfr_hit_o,
  input  wire logic             opcode_valid_i,
  input  wire logic [7:0]       opcode_i,
  input  wire dptr_pkg::ptr_op_t op_i,
  input  wire logic [PTR_W-1:0] load_value_i,
  output logic      [PTR_W-1:0] active_ptr_o,
  output logic      [PTR_W-1:0] jump_ptr_o,
  output logic                  pointer_select_o
);
  import dptr_pkg::*;

  initial begin
    if (PTR_W != 16) $error("pointer width must be 16");
  end

  // ================================================================
  // State.
  logic [PTR_W-1:0] ptr_reg [2];
  logic [PTR_W-1:0] ptr_next [2];
  logic             sel_reg, sel_next;
  logic [3:0]       aux_other_reg, aux_other_next; // Bits 6..3 kept as 4 user bits; bit 7 reads zero.
  logic [3:0]       cfg_reg, cfg_next;     // Upper nibble: upd1 upd0 dec1 dec0.
  logic             prefix_reg, prefix_next;
  logic [PTR_W-1:0] step_out [2];
  logic             down [2];
  logic             use_idx;

  // Decrement direction for each pointer.
  assign down[0] = cfg_reg[`CFG_DEC0_BIT-4];
  assign down[1] = cfg_reg[`CFG_DEC1_BIT-4];

  // Stepper per pointer.
  for (genvar g = 0; g < 2; g++) begin : g_step
    ptr_step #(.WIDTH(PTR_W)) u_step (
      .value_i  (ptr_reg[g]),
      .down_i   (down[g]),
      .result_o (step_out[g])
    );
  end

  // Pointer used by an instruction; prefix inverts the select bit.
  assign use_idx = sel_reg ^ prefix_reg;

  // ================================================================
  // Next-state logic.
  always_comb begin
    ptr_next[0]    = ptr_reg[0];
    ptr_next[1]    = ptr_reg[1];
    sel_next       = sel_reg;
    aux_other_next = aux_other_reg;
    cfg_next       = cfg_reg;
    prefix_next    = prefix_reg;
    // Prefix flag arms on A5H and is spent by the next opcode.
    if (opcode_valid_i) begin
      prefix_next = (opcode_i == `PREFIX_OPCODE) && !prefix_reg;
    end
    // Instruction effects on the pointers.
    case (op_i)
      OP_LOAD: ptr_next[use_idx] = load_value_i;
      OP_INC:  ptr_next[use_idx] = step_out[use_idx];
      OP_CODE, OP_XRD, OP_XWR: begin
        // Post-update when enabled for the pointer used.
        if (cfg_reg[`CFG_UPD0_BIT-4 + 32'(use_idx)]) begin
          ptr_next[use_idx] = step_out[use_idx];
        end
      end
      OP_NONE, OP_JMP: begin
        // No pointer changes; the jump only reads jump_ptr_o.
      end
      default: begin
        // Codes outside the one-hot set are ignored.
      end
    endcase
    // Register writes; selected pair follows the select bit.
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `ADDR_SEL_LOW:  ptr_next[sel_reg][7:0]   = sfr_wdata_i;
        `ADDR_SEL_HIGH: ptr_next[sel_reg][15:8]  = sfr_wdata_i;
        `ADDR_ALT_LOW:  ptr_next[!sel_reg][7:0]  = sfr_wdata_i;
        `ADDR_ALT_HIGH: ptr_next[!sel_reg][15:8] = sfr_wdata_i;
        `ADDR_AUX_ONE: begin
          sel_next       = sfr_wdata_i[`AUX_SEL_BIT];
          aux_other_next = sfr_wdata_i[6:3];                     // Bit 2 ignored.
        end
        `ADDR_PTR_CFG:  cfg_next = sfr_wdata_i[7:4];
        default: begin
          // Unmapped addresses are ignored.
        end
      endcase
    end
  end

  // Register update.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_reg[0]    <= `PTR_RESET;
      ptr_reg[1]    <= `PTR_RESET;
      sel_reg       <= 1'b0;
      aux_other_reg <= `AUX_OTHER_RST;
      cfg_reg       <= `CFG_RESET;
      prefix_reg    <= 1'b0;
    end else begin
      ptr_reg[0]    <= ptr_next[0];
      ptr_reg[1]    <= ptr_next[1];
      sel_reg       <= sel_next;
      aux_other_reg <= aux_other_next;
      cfg_reg       <= cfg_next;
      prefix_reg    <= prefix_next;
    end
  end

  // ================================================================
  // Read path and pointer outputs.
  always_comb begin
    sfr_hit_o   = 1'b1;
    sfr_rdata_o = `BYTE_ZERO;
    case (sfr_addr_i)
      `ADDR_SEL_LOW:  sfr_rdata_o = ptr_reg[sel_reg][7:0];
      `ADDR_SEL_HIGH: sfr_rdata_o = ptr_reg[sel_reg][15:8];
      `ADDR_ALT_LOW:  sfr_rdata_o = ptr_reg[!sel_reg][7:0];
      `ADDR_ALT_HIGH: sfr_rdata_o = ptr_reg[!sel_reg][15:8];
      `ADDR_AUX_ONE:  sfr_rdata_o = {1'b0, aux_other_reg, 1'b0, 1'b0, sel_reg};
      `ADDR_PTR_CFG:  sfr_rdata_o = {cfg_reg, 4'h0};
      default:        sfr_hit_o = 1'b0;
    endcase
  end

  assign active_ptr_o     = ptr_reg[use_idx];
  assign jump_ptr_o       = ptr_reg[sel_reg];
  assign pointer_select_o = sel_reg;

  // ================================================================
  // Checks.
  // Named steps of the prefix and of a register write.
  // An inverting prefix byte fetched while no prefix is pending.
  sequence s_prefix_arm;
    opcode_valid_i && (opcode_i == `PREFIX_OPCODE) && !prefix_reg;
  endsequence
  // The next fetched opcode, which spends an armed prefix.
  sequence s_prefix_spend;
    prefix_reg && opcode_valid_i;
  endsequence
  // A write to the selected low byte with no instruction competing.
  sequence s_sel_low_write;
    sfr_wr_i && (sfr_addr_i == `ADDR_SEL_LOW) && (op_i == OP_NONE);
  endsequence

  // The prefix is spent by exactly one instruction.
  a_prefix_one_shot: assert property (@(posedge clk_i) disable iff (rst_i)
    s_prefix_spend |=> !prefix_reg)
    else $error("prefix lasted past one instruction");
  // Once armed, instructions act on the pointer that is not selected.
  a_prefix_inverts: assert property (@(posedge clk_i) disable iff (rst_i)
    s_prefix_arm |=> active_ptr_o == (sel_reg ? ptr_reg[0] : ptr_reg[1]))
    else $error("prefix did not pick the other pointer");
  // Spending the prefix leaves the stored select bit alone.
  a_prefix_keeps_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    s_prefix_spend ##0 !(sfr_wr_i && (sfr_addr_i == `ADDR_AUX_ONE)) |=> $stable(sel_reg))
    else $error("prefix changed the select bit");
  // The jump pointer follows the select bit even while a prefix is armed.
  a_jump_ignores_prefix: assert property (@(posedge clk_i) disable iff (rst_i)
    jump_ptr_o == (sel_reg ? ptr_reg[1] : ptr_reg[0]))
    else $error("jump pointer wrong");
  // Auxiliary bit 2 always reads as zero.
  a_bit_two_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    sfr_addr_i == `ADDR_AUX_ONE |-> sfr_rdata_o[`AUX_ZERO_BIT] == 1'b0)
    else $error("auxiliary bit 2 not zero");
  // A plain increment moves pointer zero up by one.
  a_inc_step: assert property (@(posedge clk_i) disable iff (rst_i)
    op_i == OP_INC && !sfr_wr_i && !use_idx && !down[0]
      |=> ptr_reg[0] == $past(ptr_reg[0]) + 16'h0001)
    else $error("increment wrong");
  // With its direction bit set, pointer one counts down on increment.
  a_dec_step: assert property (@(posedge clk_i) disable iff (rst_i)
    op_i == OP_INC && !sfr_wr_i && use_idx && down[1]
      |=> ptr_reg[1] == $past(ptr_reg[1]) - 16'h0001)
    else $error("decrement wrong");
  // An enabled write access steps pointer one after use.
  a_auto_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
    op_i == OP_XWR && !sfr_wr_i && use_idx && cfg_reg[`CFG_UPD1_BIT-4] && !down[1]
      |=> ptr_reg[1] == $past(ptr_reg[1]) + 16'h0001)
    else $error("auto update of pointer one wrong");
  // Without an update enable a data read leaves the pointer alone.
  a_auto_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    op_i == OP_XRD && !sfr_wr_i && cfg_reg == 4'h0 |=> $stable(ptr_reg[0]))
    else $error("pointer moved without update enable");
  // A write to the selected low byte lands in the pointer chosen at that time.
  a_sel_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sel_low_write |=> ($past(sel_reg) ? ptr_reg[1][7:0] : ptr_reg[0][7:0])
      == $past(sfr_wdata_i))
    else $error("selected low byte write misplaced");
  // The alternate low byte shows the pointer that is not selected.
  a_alt_map: assert property (@(posedge clk_i) disable iff (rst_i)
    sfr_addr_i == `ADDR_ALT_LOW |-> sfr_rdata_o == ptr_reg[!sel_reg][7:0])
    else $error("alternate low byte wrong");
  // The selected high byte shows the selected pointer.
  a_sel_map: assert property (@(posedge clk_i) disable iff (rst_i)
    sfr_addr_i == `ADDR_SEL_HIGH |-> sfr_rdata_o == ptr_reg[sel_reg][15:8])
    else $error("selected high byte wrong");
endmodule // dual_data_pointer_unit

// [design/ptr_step.sv]
`timescale 1ns/1ps
// ==================================================================
// Wrapping plus or minus one on a pointer.
module ptr_step #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic             down_i,
  output logic      [WIDTH-1:0] result_o
);
  initial begin
    if (WIDTH < 2) $error("ptr_step width too small");
  end
  // Step wraps modulo two to the width, no flags produced.
  always_comb begin
    result_o = down_i ? value_i - WIDTH'(1) : value_i + WIDTH'(1);
  end
endmodule // ptr_step

// [verification/core_model.sv]
`timescale 1ns/1ps
// ================================================================
// Decoder side: issues opcode bytes and pointer actions.
module core_model (
  input  wire logic               clk_i,
  output logic                    opcode_valid_o,
  output logic [7:0]              opcode_o,
  output dptr_pkg::ptr_op_t       op_o,
  output logic [15:0]             load_value_o
);
  import dptr_pkg::*;
  // Idle decoder at time zero.
  initial begin
    opcode_valid_o = 1'b0;
    opcode_o       = 8'h00;
    op_o           = OP_NONE;
    load_value_o   = 16'h0000;
  end
  // Prefix byte; the next fetched opcode consumes it.
  task automatic pfx();
    @(posedge clk_i);
    opcode_valid_o <= 1'b1;
    opcode_o       <= 8'hA5;
    @(posedge clk_i);
    opcode_valid_o <= 1'b0;
  endtask
  // One instruction with its pointer action in the fetch cycle.
  task automatic instr(input ptr_op_t op, input logic [15:0] v);
    @(posedge clk_i);
    opcode_valid_o <= 1'b1;
    opcode_o       <= 8'h00;
    op_o           <= op;
    load_value_o   <= v;
    @(posedge clk_i);
    opcode_valid_o <= 1'b0;
    op_o           <= OP_NONE;
  endtask
endmodule // core_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
// ================================================================
// Self-checking bench for the dual pointer unit.
module tb_top;
  import dptr_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        wr_en = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, opc;
  logic        hit, opv, psel;
  ptr_op_t     op;
  logic [15:0] ldv, act, jmp;
  int          failures = 0;
  int          n_tests = 0;
  // Clock of 5 ns period.
  always #2.5 clk_i = ~clk_i;
  core_model core_u (.clk_i(clk_i), .opcode_valid_o(opv), .opcode_o(opc), .op_o(op),
    .load_value_o(ldv));
  dual_data_pointer_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr_en), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .opcode_valid_i(opv), .opcode_i(opc), .op_i(op), .load_value_i(ldv),
    .active_ptr_o(act), .jump_ptr_o(jmp), .pointer_select_o(psel));
  // Byte and pointer comparisons.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t pointer %h not %h", $time, got, exp);
    end
  endtask
  // Register write: one-cycle strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_i);
    wr_en <= 1'b0;
  endtask
  // Register read: data is combinational, sampled mid-cycle.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    @(negedge clk_i);
    chk8(rdata, exp);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run.
  initial begin
    #5000;
    failures++;
    $display("FAIL t=%0t watchdog expired", $time);
    complete_run();
  end
  // Test sequence.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h82, 8'h00);
    rdchk(8'hA2, 8'h00);
    rdchk(8'hA1, 8'h00);
    chk8({7'h00, hit}, 8'h01);
    rdchk(8'h10, 8'h00);
    chk8({7'h00, hit}, 8'h00);
    $display("Test reset done");
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    wr(8'hD4, 8'h78);
    wr(8'hD5, 8'h56);
    rdchk(8'h83, 8'h12);
    rdchk(8'hD4, 8'h78);
    wr(8'hA2, 8'hFF);
    rdchk(8'hA2, 8'h79);
    chk8({7'h00, psel}, 8'h01);
    rdchk(8'h82, 8'h78);
    rdchk(8'hD5, 8'h12);
    wr(8'hA2, 8'h78);
    $display("Test mapping done");
    core_u.pfx();
    @(negedge clk_i);
    chk16(act, 16'h5678);
    chk16(jmp, 16'h1234);
    core_u.instr(OP_INC, 16'h0000);
    rdchk(8'hD4, 8'h79);
    chk8({7'h00, psel}, 8'h00);
    chk16(act, 16'h1234);
    core_u.pfx();
    core_u.instr(OP_JMP, 16'h0000);
    @(negedge clk_i);
    chk16(jmp, 16'h1234);
    chk16(act, 16'h1234);
    rdchk(8'hD4, 8'h79);
    $display("Test prefix done");
    wr(8'hA1, 8'h10);
    rdchk(8'hA1, 8'h10);
    core_u.instr(OP_INC, 16'h0000);
    @(negedge clk_i);
    chk16(act, 16'h1233);
    wr(8'hA1, 8'h20);
    core_u.pfx();
    core_u.instr(OP_INC, 16'h0000);
    rdchk(8'hD4, 8'h78);
    wr(8'hA1, 8'h50);
    core_u.instr(OP_XRD, 16'h0000);
    core_u.instr(OP_CODE, 16'h0000);
    @(negedge clk_i);
    chk16(act, 16'h1231);
    wr(8'hA1, 8'h80);
    core_u.pfx();
    core_u.instr(OP_XWR, 16'h0000);
    rdchk(8'hD4, 8'h79);
    core_u.instr(OP_XRD, 16'h0000);
    @(negedge clk_i);
    chk16(act, 16'h1231);
    wr(8'hA1, 8'h00);
    core_u.instr(OP_XRD, 16'h0000);
    @(negedge clk_i);
    chk16(act, 16'h1231);
    core_u.instr(OP_LOAD, 16'hFFFF);
    core_u.instr(OP_INC, 16'h0000);
    @(negedge clk_i);
    chk16(act, 16'h0000);
    $display("Test update done");
    // Interrupted code runs with auto decrement; the handler saves and restores.
    wr(8'hA1, 8'h50);
    wr(8'hA1, 8'h00);
    core_u.instr(OP_LOAD, 16'h4321);
    core_u.instr(OP_XWR, 16'h0000);
    rdchk(8'h83, 8'h43);
    wr(8'h82, 8'h00);
    wr(8'h83, 8'h00);
    wr(8'hA1, 8'h50);
    core_u.instr(OP_XRD, 16'h0000);
    @(negedge clk_i);
    chk16(act, 16'hFFFF);
    $display("Test interrupt done");
    // Reset in mid-run must clear the select, configuration and both pointers.
    wr(8'hA2, 8'h01);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'hA2, 8'h00);
    rdchk(8'hA1, 8'h00);
    rdchk(8'h82, 8'h00);
    rdchk(8'hD5, 8'h00);
    $display("Test reset again done");
    complete_run();
  end
endmodule // tb_top
